// ===== src/pbdac_pkg.sv
package pbdac_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [6:0] POWER_CONTROL_THREE_OFS = 7'h03;
  localparam logic [6:0] PLAYBACK_CONVERTER_CONTROL_OFS = 7'h0A;
  localparam logic [6:0] LEFT_PLAYBACK_VOLUME_OFS = 7'h0B;
  localparam logic [6:0] RIGHT_PLAYBACK_VOLUME_OFS = 7'h0C;
  localparam logic [6:0] EQUALISER_BAND_ONE_AND_PATH_OFS = 7'h12;
  localparam logic [6:0] EQUALISER_BAND_TWO_OFS = 7'h13;
  localparam logic [6:0] OUTPUT_LIMITER_TIMING_OFS = 7'h18;
  localparam logic [6:0] OUTPUT_LIMITER_LEVEL_BOOST_OFS = 7'h19;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LEFT_EN_BIT = 0;
  localparam int RIGHT_EN_BIT = 1;
  localparam int LEFT_INV_BIT = 0;
  localparam int RIGHT_INV_BIT = 1;
  localparam int AUTO_MUTE_BIT = 2;
  localparam int OSR_BIT = 3;
  localparam int SOFT_MUTE_OFF_BIT = 6;
  localparam int UPDATE_BIT = 8;
  localparam int LIMITER_ON_BIT = 8;
  localparam int PATH_BIT = 8;
  localparam int WIDTH_BIT = 8;
  localparam int ATTACK_LSB = 0;
  localparam int DECAY_LSB = 4;
  localparam int BOOST_LSB = 0;
  localparam int LEVEL_LSB = 4;
  localparam int BAND_GAIN_LSB = 0;
  localparam int BAND_FREQ_LSB = 5;

  // ---------------------------------------------------------------
  // reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [8:0] POWER_RST = 9'h000;
  localparam logic [8:0] CONTROL_RST = 9'h000;
  localparam logic [7:0] VOLUME_RST = 8'hFF;
  localparam logic [8:0] BAND_ONE_RST = 9'h12C;
  localparam logic [8:0] BAND_TWO_RST = 9'h02C;
  localparam logic [8:0] LIM_TIMING_RST = 9'h032;
  localparam logic [8:0] LIM_LEVEL_RST = 9'h000;
  localparam logic [8:0] POWER_MASK = 9'h003;
  localparam logic [8:0] CONTROL_MASK = 9'h04F;
  localparam logic [8:0] BAND_MASK = 9'h17F;
  localparam logic [8:0] LIM_TIMING_MASK = 9'h1FF;
  localparam logic [8:0] LIM_LEVEL_MASK = 9'h07F;

  // ---------------------------------------------------------------
  // gain arithmetic and timing, in half-dB units and samples
  // ---------------------------------------------------------------
  localparam int AUTO_MUTE_SAMPLES = 1024;
  localparam logic [7:0] VOLUME_FULL = 8'hFF;
  localparam logic [8:0] SOFT_MUTE_FULL = 9'h0FF;
  localparam logic [3:0] BOOST_MAX = 4'hC;
  localparam logic [2:0] LEVEL_MAX = 3'h5;
  localparam logic [9:0] BOOST_OFFSET = 10'h018;
  localparam logic [3:0] RATE_CODE_MAX = 4'hB;
  localparam int GAIN_FRAC = 16;
  localparam logic [21:0] LIM_ATT_MAX = 22'h3F0000;
  localparam longint REF_RATE_HZ = 44100;
  localparam longint ATTACK_BASE_NS = 94000;
  localparam longint DECAY_BASE_NS = 750000;
  localparam longint HALF_DB_PER_6DB = 12;
  localparam logic [21:0] ATTACK_INCR = 22'(HALF_DB_PER_6DB * (64'd1 << GAIN_FRAC)
    * 64'd1000000000 / (ATTACK_BASE_NS * REF_RATE_HZ));
  localparam logic [21:0] DECAY_INCR = 22'(HALF_DB_PER_6DB * (64'd1 << GAIN_FRAC)
    * 64'd1000000000 / (DECAY_BASE_NS * REF_RATE_HZ));

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic signed [23:0] left;
    logic signed [23:0] right;
  } pbdac_pair_t;

  typedef struct packed {
    logic [4:0] band_one_gain;
    logic [1:0] band_one_cutoff;
    logic [4:0] band_two_gain;
    logic [1:0] band_two_centre;
    logic band_two_width;
  } pbdac_eq_cfg_t;

endpackage

// ===== src/pbdac_playback_path.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
// Overview of operation
// RULE_01: each channel runs only while enabled
// RULE_02: soft mute ramps level down, release ramps up
// RULE_03: software clears soft mute before playback
// RULE_04: per-channel phase invert bits, default off
// RULE_05: auto-mute after 1024 zeros, release immediately
// RULE_06: bit 3 selects 64x or 128x oversampling
// RULE_07: volume half-dB steps, code zero mutes
// RULE_08: volume codes reset to full scale
// RULE_09: volumes pending until update bit written
// RULE_10: limiter attacks above upper threshold
// RULE_11: limiter decays below lower threshold to 0dB
// RULE_12: thresholds half a dB around level
// RULE_13: level code maps -1 to -6 dB
// RULE_14: attack time doubles per code, clamps
// RULE_15: decay time doubles per code, clamps
// RULE_16: limiter works only while enabled
// RULE_17: boost adds 0 to 12 dB always
// RULE_18: path select, change only when idle
// RULE_19: software sets high rate mode before equaliser
// RULE_20: equaliser band controls feed filter engine
// RULE_21: band one gain and cutoff fields
// RULE_22: band two gain and centre fields
// RULE_23: band two width select, default narrow
// RULE_24: gain changes only on sample boundaries; volume updates and limiter disable take effect at once
module pbdac_playback_path import pbdac_pkg::*; #(
  parameter int AUTO_MUTE_LEN = AUTO_MUTE_SAMPLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [8:0] reg_rdata,
  input wire logic in_valid,
  input wire pbdac_pair_t in_pair,
  output logic out_valid,
  output pbdac_pair_t out_pair,
  output logic output_mute,
  output logic left_converter_enable,
  output logic right_converter_enable,
  output logic oversample_ratio_select,
  output logic effects_path_select,
  output pbdac_eq_cfg_t eq_cfg
);

  // the eleven-bit zero-run counter tops out at 2047
  if (AUTO_MUTE_LEN < 1 || AUTO_MUTE_LEN > 2047) begin : g_bad_len
    $error("AUTO_MUTE_LEN out of range");
  end

  // the slowest decay step must still move the gain
  if ((DECAY_INCR >> RATE_CODE_MAX) == 22'h0) begin : g_bad_step
    $error("decay step rounds to zero");
  end

  // -----------------------------------------------------------------
  // register bus
  // -----------------------------------------------------------------
  // register state
  logic [8:0] power_q;
  logic [8:0] control_q;
  logic [8:0] band_one_q;
  logic [8:0] band_two_q;
  logic [8:0] lim_timing_q;
  logic [8:0] lim_level_q;
  logic [8:0] rdata_q;
  logic [7:0] left_pend_q;
  logic [7:0] right_pend_q;
  logic [7:0] left_vol_q;
  logic [7:0] right_vol_q;

  // address decode
  wire logic hit_power = reg_addr == POWER_CONTROL_THREE_OFS;
  wire logic hit_control = reg_addr == PLAYBACK_CONVERTER_CONTROL_OFS;
  wire logic hit_left = reg_addr == LEFT_PLAYBACK_VOLUME_OFS;
  wire logic hit_right = reg_addr == RIGHT_PLAYBACK_VOLUME_OFS;
  wire logic hit_band_one = reg_addr == EQUALISER_BAND_ONE_AND_PATH_OFS;
  wire logic hit_band_two = reg_addr == EQUALISER_BAND_TWO_OFS;
  wire logic hit_timing = reg_addr == OUTPUT_LIMITER_TIMING_OFS;
  wire logic hit_level = reg_addr == OUTPUT_LIMITER_LEVEL_BOOST_OFS;

  // read selection; unmapped addresses read zero
  wire logic [8:0] rd_mux =
    hit_power ? power_q :
    hit_control ? control_q :
    hit_left ? {1'b0, left_pend_q} :
    hit_right ? {1'b0, right_pend_q} :
    hit_band_one ? band_one_q :
    hit_band_two ? band_two_q :
    hit_timing ? lim_timing_q :
    hit_level ? lim_level_q : 9'h000;

  // path bit only moves while both converters are off
  wire logic path_locked = power_q[LEFT_EN_BIT] | power_q[RIGHT_EN_BIT];
  wire logic [8:0] band_one_mask = path_locked ? (BAND_MASK & ~(9'h001 << PATH_BIT))
                                               : BAND_MASK;
  // volume latch decode; the update bit is never stored
  wire logic vol_update = reg_wr & (hit_left | hit_right) & reg_wdata[UPDATE_BIT];
  wire logic [7:0] new_left = (reg_wr & hit_left) ? reg_wdata[7:0] : left_pend_q;
  wire logic [7:0] new_right = (reg_wr & hit_right) ? reg_wdata[7:0] : right_pend_q;

  // configuration register writes
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      power_q <= POWER_RST;
      control_q <= CONTROL_RST; // RULE_03
      band_one_q <= BAND_ONE_RST; // RULE_21
      band_two_q <= BAND_TWO_RST; // RULE_22
      lim_timing_q <= LIM_TIMING_RST;
      lim_level_q <= LIM_LEVEL_RST;
    end else if (reg_wr) begin
      if (hit_power) begin
        power_q <= reg_wdata & POWER_MASK;
      end else if (hit_control) begin
        control_q <= reg_wdata & CONTROL_MASK;
      end else if (hit_band_one) begin
        band_one_q <= (reg_wdata & band_one_mask) | (band_one_q & ~band_one_mask); // RULE_18
      end else if (hit_band_two) begin
        band_two_q <= reg_wdata & BAND_MASK; // RULE_23
      end else if (hit_timing) begin
        lim_timing_q <= reg_wdata & LIM_TIMING_MASK;
      end else if (hit_level) begin
        lim_level_q <= reg_wdata & LIM_LEVEL_MASK;
      end
    end
  end

  // -----------------------------------------------------------------
  // volume latch
  // -----------------------------------------------------------------
  // pending and applied volume codes
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      left_pend_q <= VOLUME_RST; // RULE_08
      right_pend_q <= VOLUME_RST;
      left_vol_q <= VOLUME_RST;
      right_vol_q <= VOLUME_RST;
    end else begin
      left_pend_q <= new_left;
      right_pend_q <= new_right;
      if (vol_update) begin
        left_vol_q <= new_left; // RULE_09
        right_vol_q <= new_right;
      end
    end
  end

  // -----------------------------------------------------------------
  // read port
  // -----------------------------------------------------------------
  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_q <= 9'h000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 9'h000;
    end
  end

  assign reg_rdata = rdata_q;

  // -----------------------------------------------------------------
  // control fields
  // -----------------------------------------------------------------
  // field extraction, reserved codes clamped
  wire logic left_on = power_q[LEFT_EN_BIT];
  wire logic right_on = power_q[RIGHT_EN_BIT];
  wire logic soft_mute_on = ~control_q[SOFT_MUTE_OFF_BIT];
  wire logic limiter_on = lim_timing_q[LIMITER_ON_BIT];
  wire logic [3:0] atk_raw = lim_timing_q[ATTACK_LSB +: 4];
  wire logic [3:0] dcy_raw = lim_timing_q[DECAY_LSB +: 4];
  wire logic [3:0] boost_raw = lim_level_q[BOOST_LSB +: 4];
  wire logic [2:0] level_raw = lim_level_q[LEVEL_LSB +: 3];
  wire logic [3:0] atk_code = (atk_raw > RATE_CODE_MAX) ? RATE_CODE_MAX : atk_raw; // RULE_14
  wire logic [3:0] dcy_code = (dcy_raw > RATE_CODE_MAX) ? RATE_CODE_MAX : dcy_raw; // RULE_15
  wire logic [3:0] boost = (boost_raw > BOOST_MAX) ? BOOST_MAX : boost_raw; // RULE_17
  wire logic [2:0] level = (level_raw > LEVEL_MAX) ? LEVEL_MAX : level_raw; // RULE_13

  // level outputs straight from the registers
  assign left_converter_enable = left_on;
  assign right_converter_enable = right_on;
  assign oversample_ratio_select = control_q[OSR_BIT]; // RULE_06
  assign effects_path_select = band_one_q[PATH_BIT]; // RULE_18

  // -----------------------------------------------------------------
  // equaliser settings
  // -----------------------------------------------------------------
  // band settings for the shelving and peak filter engine
  assign eq_cfg.band_one_gain = band_one_q[BAND_GAIN_LSB +: 5]; // RULE_20
  assign eq_cfg.band_one_cutoff = band_one_q[BAND_FREQ_LSB +: 2]; // RULE_21
  assign eq_cfg.band_two_gain = band_two_q[BAND_GAIN_LSB +: 5]; // RULE_22
  assign eq_cfg.band_two_centre = band_two_q[BAND_FREQ_LSB +: 2];
  assign eq_cfg.band_two_width = band_two_q[WIDTH_BIT]; // RULE_23

  // -----------------------------------------------------------------
  // gain helpers
  // -----------------------------------------------------------------
  // mantissa of 10^(-r/40) in Q15, one entry per half dB
  function automatic logic [15:0] mant(input logic [3:0] r);
    case (r)
      4'h0: mant = 16'h8000;
      4'h1: mant = 16'h78D7;
      4'h2: mant = 16'h7215;
      4'h3: mant = 16'h6BB3;
      4'h4: mant = 16'h65AD;
      4'h5: mant = 16'h5FFD;
      4'h6: mant = 16'h5A9E;
      4'h7: mant = 16'h558C;
      4'h8: mant = 16'h50C3;
      4'h9: mant = 16'h4C3F;
      4'hA: mant = 16'h47FB;
      default: mant = 16'h43F4;
    endcase
  endfunction

  // attenuation of att half-dB after a fixed 12 dB lift
  function automatic logic signed [23:0] apply_gain(input logic signed [23:0] s,
                                                   input logic [9:0] att);
    logic [6:0] q;
    logic [3:0] r;
    logic signed [41:0] p;
    logic signed [41:0] sh;
    q = 7'(att / 10'd12);
    r = 4'(att % 10'd12);
    p = 42'(s) * 42'($signed({1'b0, mant(r)}));
    sh = p >>> (q + 7'd13);
    if (sh > 42'sh7FFFFF) begin
      apply_gain = 24'sh7FFFFF;
    end else if (sh < -42'sh7FFFFF) begin
      apply_gain = -24'sh7FFFFF;
    end else begin
      apply_gain = sh[23:0];
    end
  endfunction

  // full-scale magnitude h half-dB below the top
  function automatic logic [23:0] threshold(input logic [3:0] h);
    threshold = {mant(4'(h % 4'd12)), 8'h00} >> (h / 4'd12);
  endfunction

  // absolute value of a signed sample
  function automatic logic [23:0] magnitude(input logic signed [23:0] s);
    magnitude = s[23] ? 24'(-s) : 24'(s);
  endfunction

  // -----------------------------------------------------------------
  // gain path, evaluated once per sample
  // -----------------------------------------------------------------
  // gain, zero-run and output state
  logic [8:0] mute_att_q;
  logic [21:0] lim_att_q;
  logic [10:0] zero_run_q;
  logic auto_mute_q;
  logic out_valid_q;
  pbdac_pair_t out_pair_q;

  // attenuation in half dB; boost nets out the fixed lift
  wire logic [9:0] common_att = 10'(mute_att_q) + 10'(lim_att_q[21:GAIN_FRAC])
                              + BOOST_OFFSET - 10'({boost, 1'b0}); // RULE_17
  wire logic [9:0] left_att = 10'(VOLUME_FULL - left_vol_q) + common_att; // RULE_07
  wire logic [9:0] right_att = 10'(VOLUME_FULL - right_vol_q) + common_att;
  wire logic muted = mute_att_q >= SOFT_MUTE_FULL; // RULE_02
  wire logic left_zero = !left_on || left_vol_q == 8'h00 || muted; // RULE_07
  wire logic right_zero = !right_on || right_vol_q == 8'h00 || muted;
  wire logic signed [23:0] left_gain = left_zero ? 24'sh000000
                                                 : apply_gain(in_pair.left, left_att);
  wire logic signed [23:0] right_gain = right_zero ? 24'sh000000
                                                   : apply_gain(in_pair.right, right_att);
  // limiter detector follows the louder channel
  wire logic [23:0] left_mag = magnitude(left_gain);
  wire logic [23:0] right_mag = magnitude(right_gain);
  wire logic [23:0] peak = (left_mag > right_mag) ? left_mag : right_mag;

  // -----------------------------------------------------------------
  // limiter detector
  // -----------------------------------------------------------------
  // thresholds straddle the programmed level by half a dB
  wire logic [3:0] level_half_db = 4'({level, 1'b0}) + 4'd2; // RULE_13
  wire logic [23:0] upper_thr = threshold(level_half_db - 4'd1); // RULE_12
  wire logic [23:0] lower_thr = threshold(level_half_db + 4'd1); // RULE_12
  wire logic [21:0] atk_step = ATTACK_INCR >> atk_code; // RULE_14
  wire logic [21:0] dcy_step = DECAY_INCR >> dcy_code; // RULE_15
  wire logic [22:0] att_up = 23'(lim_att_q) + 23'(atk_step);
  wire logic over_upper = peak > upper_thr;
  wire logic under_lower = peak < lower_thr;

  // -----------------------------------------------------------------
  // output stage
  // -----------------------------------------------------------------
  // phase inversion after gain, both channels default upright
  wire logic signed [23:0] left_out = control_q[LEFT_INV_BIT] ? -left_gain : left_gain;
  wire logic signed [23:0] right_out = control_q[RIGHT_INV_BIT] ? -right_gain : right_gain;

  // output sample register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      out_valid_q <= 1'b0;
      out_pair_q <= '0;
    end else begin
      out_valid_q <= in_valid;
      if (in_valid) begin
        out_pair_q.left <= left_out; // RULE_04
        out_pair_q.right <= right_out; // RULE_04
      end
    end
  end

  // -----------------------------------------------------------------
  // soft mute
  // -----------------------------------------------------------------
  // soft mute ramp, one half dB per sample
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mute_att_q <= SOFT_MUTE_FULL;
    end else if (in_valid) begin
      if (soft_mute_on && mute_att_q < SOFT_MUTE_FULL) begin
        mute_att_q <= mute_att_q + 9'd1; // RULE_02
      end else if (!soft_mute_on && mute_att_q != 9'h000) begin
        mute_att_q <= mute_att_q - 9'd1; // RULE_02
      end
    end
  end

  // -----------------------------------------------------------------
  // output limiter
  // -----------------------------------------------------------------
  // limiter gain, moved at sample boundaries; cleared at once while disabled
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lim_att_q <= '0;
    end else if (!limiter_on) begin
      lim_att_q <= '0; // RULE_16
    end else if (in_valid) begin // RULE_24
      if (over_upper) begin
        lim_att_q <= (att_up > 23'(LIM_ATT_MAX)) ? LIM_ATT_MAX : att_up[21:0]; // RULE_10
      end else if (under_lower) begin
        lim_att_q <= (lim_att_q > dcy_step) ? lim_att_q - dcy_step : '0; // RULE_11
      end
    end
  end

  // -----------------------------------------------------------------
  // auto-mute
  // -----------------------------------------------------------------
  // zero-run detector for the analogue mute
  wire logic in_silent = (!left_on || in_pair.left == 24'sh000000)
                       && (!right_on || in_pair.right == 24'sh000000);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      zero_run_q <= '0;
      auto_mute_q <= 1'b0;
    end else if (!control_q[AUTO_MUTE_BIT]) begin
      zero_run_q <= '0;
      auto_mute_q <= 1'b0;
    end else if (in_valid) begin
      if (!in_silent) begin
        zero_run_q <= '0;
        auto_mute_q <= 1'b0; // RULE_05
      end else if (zero_run_q < 11'(AUTO_MUTE_LEN)) begin
        zero_run_q <= zero_run_q + 11'd1;
        auto_mute_q <= (zero_run_q + 11'd1) == 11'(AUTO_MUTE_LEN); // RULE_05
      end
    end
  end

  // -----------------------------------------------------------------
  // port outputs
  // -----------------------------------------------------------------
  assign out_valid = out_valid_q;
  assign out_pair = out_pair_q; // RULE_01
  assign output_mute = auto_mute_q;

endmodule

// ===== testbench/pbdac_monitor.sv
`timescale 1ns/1ns
module pbdac_monitor import pbdac_pkg::*; #(
  parameter int AUTO_MUTE_LEN = 1024
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [8:0] reg_rdata,
  input wire logic in_valid,
  input wire pbdac_pair_t in_pair,
  input wire logic out_valid,
  input wire pbdac_pair_t out_pair,
  input wire logic output_mute,
  input wire logic left_converter_enable,
  input wire logic right_converter_enable,
  input wire logic oversample_ratio_select,
  input wire logic effects_path_select,
  input wire pbdac_eq_cfg_t eq_cfg
);
  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_ENABLE_WRITE: assert property (reg_wr && reg_addr == POWER_CONTROL_THREE_OFS |=>
    left_converter_enable == $past(reg_wdata[0]) && right_converter_enable == $past(reg_wdata[1]))
    else $error("converter enables do not follow the power write");
  AST_OFF_SILENT: assert property (in_valid && !left_converter_enable |=>
    out_valid && out_pair.left == 24'h000000) else $error("disabled left channel not silent");
  AST_OSR_WRITE: assert property (reg_wr && reg_addr == PLAYBACK_CONVERTER_CONTROL_OFS |=>
    oversample_ratio_select == $past(reg_wdata[3])) else $error("oversample select wrong");
  AST_MUTE_RELEASE: assert property (output_mute && in_valid && left_converter_enable
    && right_converter_enable && in_pair != '0 |=> !output_mute) else $error("mute not released");
  AST_MUTE_CAUSE: assert property ($rose(output_mute) |-> $past(in_valid))
    else $error("mute rose without a sample");
  AST_MUTE_HOLD: assert property (!in_valid && !$past(reg_wr) |=> $stable(output_mute))
    else $error("mute changed between samples");
  AST_PATH_LOCK: assert property (left_converter_enable || right_converter_enable
    |=> $stable(effects_path_select)) else $error("path select changed while running");
  AST_SAMPLE_HOLD: assert property (!out_valid |-> $stable(out_pair))
    else $error("output pair changed off a sample boundary");
  AST_VALID_PULSE: assert property (in_valid |=> out_valid ##1 (out_valid == $past(in_valid)))
    else $error("output strobe not one cycle after input");
endmodule

bind pbdac_playback_path pbdac_monitor #(.AUTO_MUTE_LEN(AUTO_MUTE_LEN)) i_monitor (
  .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
  .in_pair(in_pair), .out_valid(out_valid), .out_pair(out_pair), .output_mute(output_mute),
  .left_converter_enable(left_converter_enable), .right_converter_enable(right_converter_enable),
  .oversample_ratio_select(oversample_ratio_select),
  .effects_path_select(effects_path_select), .eq_cfg(eq_cfg));

// ===== testbench/pbdac_sample_source.sv
`timescale 1ns/1ns
module pbdac_sample_source import pbdac_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic send_req,
  input wire pbdac_pair_t send_pair,
  output logic in_valid,
  output pbdac_pair_t in_pair
);
  // one pair per request; data lines toggle between samples
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      in_valid <= 1'b0;
      in_pair <= '0;
    end else begin
      in_valid <= send_req;
      in_pair <= send_req ? send_pair : ~in_pair;
    end
  end
endmodule

// ===== testbench/playback_dac_digital_path_tb.sv
`timescale 1ns/1ns
module playback_dac_digital_path_tb import pbdac_pkg::*;;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [8:0] reg_wdata = 9'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [8:0] reg_rdata, rd_val, d;
  logic src_req = 1'b0;
  pbdac_pair_t src_pair = '0;
  logic in_valid, out_valid, output_mute, lce, rce, osr, path;
  pbdac_pair_t in_pair, out_pair;
  pbdac_eq_cfg_t eq_cfg;
  int fail_count = 0, total_checks = 0, cycles = 0, seed = 18, i;
  logic [6:0] ofs [9] = '{7'h03, 7'h0A, 7'h0B, 7'h0C, 7'h12, 7'h13, 7'h18, 7'h19, 7'h7F};
  logic [8:0] rst [9] = '{9'h000, 9'h000, 9'h0FF, 9'h0FF, 9'h12C, 9'h02C, 9'h032, 9'h000, 9'h000};
  localparam logic [23:0] BIG = 24'h400000;
  localparam logic [23:0] SAT = 24'h7FFFFF;
  localparam logic [23:0] NEG = 24'h800001;

  // ---------------------------------------------------------------
  // design, far side, clock and watchdog
  // ---------------------------------------------------------------
  pbdac_playback_path #(.AUTO_MUTE_LEN(4)) i_dut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_pair(in_pair), .out_valid(out_valid), .out_pair(out_pair), .output_mute(output_mute),
    .left_converter_enable(lce), .right_converter_enable(rce),
    .oversample_ratio_select(osr), .effects_path_select(path), .eq_cfg(eq_cfg));
  pbdac_sample_source i_source (.core_clk(core_clk), .resetn(resetn), .send_req(src_req),
    .send_pair(src_pair), .in_valid(in_valid), .in_pair(in_pair));
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // bus, stream and compare helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] band_fields(input logic [8:0] v);
    return {v[8], v[6:5], v[4:0]};
  endfunction
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [8:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [6:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic send(input logic [23:0] l, input logic [23:0] r);
    int k;
    @(posedge core_clk);
    src_req <= 1'b1;
    src_pair <= {l, r};
    @(posedge core_clk);
    src_req <= 1'b0;
    for (k = 0; k < 4 && out_valid !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    for (i = 0; i < 9; i++) begin
      rd(ofs[i]);
      chk(rd_val, rst[i]);
    end
    chk({path, eq_cfg}, {1'b1, 5'h0C, 2'h1, 5'h0C, 2'h1, 1'b0});
    for (i = 0; i < 4; i++) begin
      d = 9'($random(seed));
      wr(7'h13, d);
      rd(7'h13);
      chk(rd_val, d & BAND_MASK);
      chk({eq_cfg.band_two_width, eq_cfg.band_two_centre, eq_cfg.band_two_gain},
        band_fields(d));
      d = 9'($random(seed));
      wr(7'h12, d);
      chk({path, eq_cfg.band_one_cutoff, eq_cfg.band_one_gain}, band_fields(d));
      wr(7'h18, d);
      rd(7'h18);
      chk(rd_val, d & LIM_TIMING_MASK);
    end
    wr(7'h12, 9'h12C);
    wr(7'h0B, 9'h080);
    rd(7'h0B);
    chk(rd_val, 9'h080);
    wr(7'h0B, 9'h1FF);
    wr(7'h18, 9'h000);
    wr(7'h03, 9'h003);
    chk({lce, rce}, 2'h3);
    wr(7'h19, 9'h00C);
    wr(7'h0A, 9'h040);
    send(BIG, BIG);
    chk(out_pair.left < 24'h001000, 1'b1);
    repeat (260) send(BIG, BIG);
    chk(out_pair, {SAT, SAT});
    wr(7'h0A, 9'h043);
    send(BIG, BIG);
    chk(out_pair, {NEG, NEG});
    wr(7'h0A, 9'h041);
    send(BIG, BIG);
    chk(out_pair, {NEG, SAT});
    wr(7'h0A, 9'h040);
    wr(7'h0B, 9'h000);
    send(BIG, BIG);
    chk(out_pair, {SAT, SAT});
    wr(7'h0C, 9'h1FF);
    send(BIG, BIG);
    chk(out_pair, {24'h000000, SAT});
    wr(7'h0B, 9'h1FF);
    wr(7'h03, 9'h002);
    send(BIG, BIG);
    chk(out_pair, {24'h000000, SAT});
    wr(7'h12, 9'h02C);
    rd(7'h12);
    chk({rd_val, path}, {9'h12C, 1'b1});
    wr(7'h03, 9'h003);
    wr(7'h0A, 9'h044);
    repeat (3) send(24'h000000, 24'h000000);
    chk(output_mute, 1'b0);
    send(24'h000000, 24'h000000);
    chk(output_mute, 1'b1);
    send({8'h00, 16'($random(seed)) | 16'h0001}, 24'h000000);
    chk(output_mute, 1'b0);
    wr(7'h0A, 9'h04C);
    chk(osr, 1'b1);
    wr(7'h0A, 9'h040);
    chk(osr, 1'b0);
    wr(7'h18, 9'h100);
    repeat (40) send(BIG, BIG);
    chk(out_pair.left !== SAT && !out_pair.left[23] && out_pair.left != 0, 1'b1);
    repeat (220) send({12'h000, 12'($random(seed))}, {12'h000, 12'($random(seed))});
    send(BIG, BIG);
    chk(out_pair, {SAT, SAT});
    wr(7'h19, 9'h07C);
    repeat (40) send(BIG, BIG);
    chk(out_pair.left >= 24'h3C0000 && out_pair.left <= 24'h440000, 1'b1);
    end_of_test();
  end
endmodule
